// file: hdl/tsl_defs.svh
`ifndef TSL_DEFS_SVH
`define TSL_DEFS_SVH
`define TSL_ADDR_TYPE_ID   4'h9
`define TSL_BIT_CNT_LAST   4'h7
`define TSL_BIT_CNT_RESET  4'h0
`define TSL_BIT_CNT_START  4'hF
`define TSL_BIT_CNT_ACK    4'h8
`define TSL_FILT_LEN       3
`define TSL_FILT_CNT_MAX   2'h3
`define TSL_RW_BIT         0
`endif

// file: hdl/tsl_pkg.sv
package tsl_pkg;
   typedef enum logic [5:0] {
      TSL_IDLE     = 6'b000001,
      TSL_ADDR     = 6'b000010,
      TSL_ADDR_ACK = 6'b000100,
      TSL_RX       = 6'b001000,
      TSL_RX_ACK   = 6'b010000,
      TSL_TX       = 6'b100000
   } tsl_state_t;
endpackage : tsl_pkg

// file: hdl/tsl_filter.sv
`timescale 1ns/1ps
`include "tsl_defs.svh"
// two-flop synchroniser then stability filter with hysteresis
module tsl_filter (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic pin_in,
   output logic      level_out
);
   logic       sync1_reg;
   logic       sync2_reg;
   logic [1:0] cnt_reg;

   // first flop only feeds the second
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   // output flips only after the new level held several samples
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_reg   <= 2'h0;
         level_out <= 1'b1;
      end else if (sync2_reg == level_out) begin
         cnt_reg <= 2'h0;
      end else if (cnt_reg == `TSL_FILT_CNT_MAX) begin
         cnt_reg   <= 2'h0;
         level_out <= sync2_reg;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
      end
   end
endmodule : tsl_filter

// file: hdl/tsl_link.sv
`timescale 1ns/1ps
`include "tsl_defs.svh"
// Overview of operation
// - sample on SCL rise, drive after fall
// - bytes shifted most significant bit first
// - eight bits then ack on ninth
// - SDA changes only while SCL low
// - SDA fall with SCL high starts
// - SDA rise with SCL high stops
// - ignore bus until Start seen
// - idle means SCL and SDA high
// - unlimited bytes between Start and Stop
// - repeated Start begins new operation
// - hold SDA low whole ack clock
// - master nack ends read, release SDA
// - nack invalid operations like read-only writes
// - filter spikes on SCL and SDA
// - address is 1001 plus select pins
// - address last bit selects direction
// - ack address match, else idle
module tsl_link
   import tsl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic [2:0] address_select_pins,
   input  wire logic       write_allowed,
   input  wire logic [7:0] tx_data,
   output logic            tx_load,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   output logic            bus_idle
);
   tsl_state_t state_reg;
   logic       scl_f;
   logic       sda_f;
   logic       scl_d_reg;
   logic       sda_d_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic       ack_reg;
   logic       nack_seen_reg;
   logic [2:0] addr_pins_reg;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;

   // filtered copies of both pins
   tsl_filter u_scl_filt (
      .clk       (clk),
      .resetn    (resetn),
      .pin_in    (scl_in),
      .level_out (scl_f)
   );
   tsl_filter u_sda_filt (
      .clk       (clk),
      .resetn    (resetn),
      .pin_in    (sda_in),
      .level_out (sda_f)
   );

   // previous filtered levels for edge detection
   always_ff @(posedge clk) begin
      if (!resetn) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_f;
         sda_d_reg <= sda_f;
      end
   end

   // straps caught by a clocked process, never by reset
   always_ff @(posedge clk) begin
      addr_pins_reg <= address_select_pins;
   end

   assign scl_rise  = scl_f & ~scl_d_reg;
   assign scl_fall  = ~scl_f & scl_d_reg;
   assign start_det = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
   assign stop_det  = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
   assign bus_idle  = scl_f & sda_f;

   // protocol sequencer; start watched in every state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg     <= TSL_IDLE;
         bit_cnt_reg   <= `TSL_BIT_CNT_RESET;
         shift_reg     <= 8'h00;
         ack_reg       <= 1'b0;
         nack_seen_reg <= 1'b0;
      end else if (start_det) begin
         state_reg   <= TSL_ADDR;
         // the start's own scl fall wraps this to zero before the first bit
         bit_cnt_reg <= `TSL_BIT_CNT_START;
         ack_reg     <= 1'b0;
      end else if (stop_det) begin
         state_reg <= TSL_IDLE;
         ack_reg   <= 1'b0;
      end else begin
         unique case (state_reg)
            TSL_IDLE: begin
               ack_reg <= 1'b0;
            end
            TSL_ADDR, TSL_RX: begin
               if (scl_rise) begin
                  shift_reg <= {shift_reg[6:0], sda_f};
               end
               if (scl_fall) begin
                  if (bit_cnt_reg == `TSL_BIT_CNT_LAST) begin
                     bit_cnt_reg <= `TSL_BIT_CNT_RESET;
                     if (state_reg == TSL_ADDR) begin
                        if (shift_reg[7:1] == {`TSL_ADDR_TYPE_ID, addr_pins_reg}) begin
                           ack_reg   <= 1'b1;
                           state_reg <= TSL_ADDR_ACK;
                        end else begin
                           state_reg <= TSL_IDLE;
                        end
                     end else begin
                        ack_reg   <= write_allowed;
                        state_reg <= TSL_RX_ACK;
                     end
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            TSL_ADDR_ACK, TSL_RX_ACK: begin
               // release only after the ack clock falls
               if (scl_fall) begin
                  ack_reg <= 1'b0;
                  if (state_reg == TSL_ADDR_ACK && shift_reg[`TSL_RW_BIT]) begin
                     state_reg     <= TSL_TX;
                     shift_reg     <= tx_data;
                     nack_seen_reg <= 1'b0;
                  end else begin
                     state_reg <= TSL_RX;
                  end
               end
            end
            TSL_TX: begin
               if (scl_rise && bit_cnt_reg == `TSL_BIT_CNT_ACK) begin
                  nack_seen_reg <= sda_f;
               end
               if (scl_fall) begin
                  if (bit_cnt_reg == `TSL_BIT_CNT_ACK) begin
                     bit_cnt_reg <= `TSL_BIT_CNT_RESET;
                     if (nack_seen_reg) begin
                        state_reg <= TSL_IDLE;
                     end else begin
                        shift_reg <= tx_data;
                     end
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     if (bit_cnt_reg != `TSL_BIT_CNT_LAST) begin
                        shift_reg <= {shift_reg[6:0], 1'b1};
                     end
                  end
               end
            end
         endcase
      end
   end

   // pull low for ack or a zero data bit; never drive high
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sda_oe <= 1'b0;
      end else if (start_det || stop_det) begin
         sda_oe <= 1'b0;
      end else begin
         sda_oe <= ((state_reg == TSL_ADDR_ACK || state_reg == TSL_RX_ACK) && ack_reg)
                   || (state_reg == TSL_TX && bit_cnt_reg != `TSL_BIT_CNT_ACK
                       && !shift_reg[7]);
      end
   end
   assign sda_out = 1'b0;

   // received byte and next-byte request strobes
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_data  <= 8'h00;
         rx_valid <= 1'b0;
         tx_load  <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         tx_load  <= 1'b0;
         if (state_reg == TSL_RX && scl_fall && bit_cnt_reg == `TSL_BIT_CNT_LAST
             && !start_det && !stop_det) begin
            rx_data  <= shift_reg;
            rx_valid <= write_allowed;
         end
         if (state_reg == TSL_TX && scl_fall && bit_cnt_reg == `TSL_BIT_CNT_ACK
             && !nack_seen_reg && !start_det && !stop_det) begin
            tx_load <= 1'b1;
         end
      end
   end

   property p_drive_only_low;
      @(posedge clk) disable iff (!resetn)
         sda_oe |-> (sda_out == 1'b0) && ($past(state_reg) inside {TSL_ADDR_ACK, TSL_RX_ACK, TSL_TX});
   endproperty
   a_drive_only_low: assert property (p_drive_only_low) else $error("sda driven high");

   property p_ack_stable_high;
      @(posedge clk) disable iff (!resetn)
         (state_reg == TSL_RX_ACK && ack_reg && scl_rise) |=> (sda_oe || start_det || stop_det);
   endproperty
   a_ack_stable_high: assert property (p_ack_stable_high) else $error("ack lost in high phase");

   property p_stop_to_idle;
      @(posedge clk) disable iff (!resetn) (stop_det && !start_det) |=> state_reg == TSL_IDLE;
   endproperty
   a_stop_to_idle: assert property (p_stop_to_idle) else $error("stop did not idle");

   property p_start_to_addr;
      @(posedge clk) disable iff (!resetn) start_det |=> state_reg == TSL_ADDR;
   endproperty
   a_start_to_addr: assert property (p_start_to_addr) else $error("start missed");

   property p_idle_silent;
      @(posedge clk) disable iff (!resetn) (state_reg == TSL_IDLE) [*2] |-> !sda_oe;
   endproperty
   a_idle_silent: assert property (p_idle_silent) else $error("driving while idle");

   property p_oe_change_scl_low;
      @(posedge clk) disable iff (!resetn)
         (state_reg != TSL_IDLE && $changed(sda_oe) && !$past(start_det) && !$past(stop_det))
         |-> !scl_d_reg || !$past(scl_d_reg);
   endproperty
   a_oe_change_scl_low: assert property (p_oe_change_scl_low) else $error("sda moved scl high");

   property p_bad_addr_idle;
      @(posedge clk) disable iff (!resetn)
         (state_reg == TSL_ADDR && scl_fall && bit_cnt_reg == `TSL_BIT_CNT_LAST && !start_det
          && !stop_det && shift_reg[7:1] != {`TSL_ADDR_TYPE_ID, addr_pins_reg})
         |=> state_reg == TSL_IDLE;
   endproperty
   a_bad_addr_idle: assert property (p_bad_addr_idle) else $error("mismatch not idled");

   property p_nack_readonly;
      @(posedge clk) disable iff (!resetn)
         (state_reg == TSL_RX && scl_fall && bit_cnt_reg == `TSL_BIT_CNT_LAST && !write_allowed
          && !start_det && !stop_det) |=> !ack_reg;
   endproperty
   a_nack_readonly: assert property (p_nack_readonly) else $error("ack on refused write");
endmodule : tsl_link

// file: tb/tsl_master_model.sv
`timescale 1ns/1ps
// bus master model: drives SCL, pulls SDA low or releases it to the pull-up
module tsl_master_model #(
   parameter int HALF = 8
) (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   // idle: both lines released, clock parked high
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end
   task automatic half_wait(input int n);
      repeat (n) @(negedge clk);
   endtask : half_wait
   // data set while low, sampled mid-high so a slow answer still lands
   task automatic bit_cycle(input logic drv, output logic got);
      sda_low = ~drv;
      half_wait(HALF);
      scl = 1'b1;
      half_wait(HALF / 2);
      got = sda;
      half_wait(HALF / 2);
      scl = 1'b0;
   endtask : bit_cycle
   // works from idle and as a repeated start with SCL low
   task automatic start_cond();
      sda_low = 1'b0;
      half_wait(HALF);
      scl = 1'b1;
      half_wait(HALF);
      sda_low = 1'b1;
      half_wait(HALF);
      scl = 1'b0;
   endtask : start_cond
   task automatic stop_cond();
      sda_low = 1'b1;
      half_wait(HALF);
      scl = 1'b1;
      half_wait(HALF);
      sda_low = 1'b0;
      half_wait(HALF);
   endtask : stop_cond
   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) bit_cycle(b[i], g);
      bit_cycle(1'b1, g);
      ack = ~g;
   endtask : write_byte
   task automatic read_byte(input logic nack, output logic [7:0] b);
      logic g;
      for (int i = 7; i >= 0; i--) bit_cycle(1'b1, b[i]);
      bit_cycle(nack, g);
   endtask : read_byte
endmodule : tsl_master_model

// file: tb/temp_sensor_i2c_slave_link_tb_top.sv
`timescale 1ns/1ps
module temp_sensor_i2c_slave_link_tb_top;
   logic       clk, resetn, scl, sda_low, sda, sda_out, sda_oe;
   logic       tx_load, rx_valid, bus_idle, write_allowed, a;
   logic [2:0] address_select_pins;
   logic [7:0] tx_data, rx_data, b;
   logic [7:0] rx_q[$];
   int         mismatches, n_compared, n_loads;
   // wire-AND with pull-up
   assign sda = ~(sda_low | (sda_oe & ~sda_out));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   tsl_link u_tsl_link (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pins(address_select_pins),
      .write_allowed(write_allowed), .tx_data(tx_data), .tx_load(tx_load),
      .rx_data(rx_data), .rx_valid(rx_valid), .bus_idle(bus_idle));
   // phases kept above the design's filter latency
   tsl_master_model #(.HALF(8)) u_tsl_master_model (.clk(clk), .sda(sda), .scl(scl),
      .sda_low(sda_low));
   // capture accepted bytes and count transmit-byte takes, mid-cycle
   always @(negedge clk) if (rx_valid === 1'b1) rx_q.push_back(rx_data);
   always @(negedge clk) if (tx_load === 1'b1) n_loads++;
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   task automatic t_write();
      rx_q.delete();
      u_tsl_master_model.start_cond();
      chk("bus_idle", 8'h00, 8'(bus_idle));
      u_tsl_master_model.write_byte({4'h9, 3'h5, 1'b0}, a);
      chk("addr ack", 8'h01, 8'(a));
      u_tsl_master_model.write_byte(8'hA5, a);
      chk("data ack", 8'h01, 8'(a));
      u_tsl_master_model.write_byte(8'h3C, a);
      chk("data ack", 8'h01, 8'(a));
      u_tsl_master_model.stop_cond();
      chk("rx count", 8'h02, 8'(rx_q.size()));
      chk("rx byte", 8'hA5, rx_q[0]);
      chk("rx byte", 8'h3C, rx_q[1]);
      chk("bus_idle", 8'h01, 8'(bus_idle));
      $display("write test done");
   endtask : t_write
   task automatic t_readonly();
      rx_q.delete();
      write_allowed = 1'b0;
      u_tsl_master_model.start_cond();
      u_tsl_master_model.write_byte({4'h9, 3'h5, 1'b0}, a);
      u_tsl_master_model.write_byte(8'h77, a);
      chk("read-only ack", 8'h00, 8'(a));
      u_tsl_master_model.stop_cond();
      chk("rx count", 8'h00, 8'(rx_q.size()));
      write_allowed = 1'b1;
      $display("read-only test done");
   endtask : t_readonly
   task automatic t_ignore();
      rx_q.delete();
      u_tsl_master_model.sda_low = 1'b1;  // one-cycle spike, no start
      @(negedge clk);
      u_tsl_master_model.sda_low = 1'b0;
      u_tsl_master_model.half_wait(8);
      u_tsl_master_model.scl = 1'b0;
      u_tsl_master_model.write_byte({4'h9, 3'h5, 1'b0}, a);
      chk("no-start ack", 8'h00, 8'(a));
      u_tsl_master_model.stop_cond();
      u_tsl_master_model.start_cond();
      u_tsl_master_model.write_byte({4'h9, 3'h2, 1'b0}, a);
      chk("mismatch ack", 8'h00, 8'(a));
      u_tsl_master_model.write_byte(8'h11, a);
      chk("after mismatch ack", 8'h00, 8'(a));
      u_tsl_master_model.stop_cond();
      chk("rx count", 8'h00, 8'(rx_q.size()));
      $display("ignore test done");
   endtask : t_ignore
   task automatic t_read();
      tx_data = 8'hC3;
      n_loads = 0;
      u_tsl_master_model.start_cond();
      u_tsl_master_model.write_byte({4'h9, 3'h5, 1'b0}, a);
      u_tsl_master_model.start_cond();
      u_tsl_master_model.write_byte({4'h9, 3'h5, 1'b1}, a);
      chk("read addr ack", 8'h01, 8'(a));
      u_tsl_master_model.read_byte(1'b0, b);
      chk("read byte", 8'hC3, b);
      // next byte ready before the device sees the master's ack clock fall
      tx_data = 8'h5A;
      u_tsl_master_model.read_byte(1'b1, b);
      chk("read byte", 8'h5A, b);
      chk("tx_load count", 8'h01, 8'(n_loads));
      u_tsl_master_model.half_wait(8);
      chk("released", 8'h00, 8'(sda_oe));
      u_tsl_master_model.stop_cond();
      chk("bus_idle", 8'h01, 8'(bus_idle));
      $display("read test done");
   endtask : t_read
   // main sequence
   initial begin
      resetn = 1'b0;
      address_select_pins = 3'h5;
      write_allowed = 1'b1;
      tx_data = 8'hC3;
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      repeat (10) @(negedge clk);
      chk("bus_idle", 8'h01, 8'(bus_idle));
      chk("sda_oe", 8'h00, 8'(sda_oe));
      t_write();
      t_readonly();
      t_ignore();
      t_read();
      report_and_stop();
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end
endmodule : temp_sensor_i2c_slave_link_tb_top
